// file: design/phymg_consts.svh
`ifndef PHYMG_CONSTS_SVH
`define PHYMG_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define PHYMG_IDX_PKT_LOW 10'h1a8
`define PHYMG_IDX_PKT_HIGH 10'h1a9
`define PHYMG_IDX_ERR_CNT 10'h1aa
`define PHYMG_IDX_MODE 10'h1df
`define PHYMG_IDX_PIN_MUX 10'h1e0
`define PHYMG_IDX_LINK_LOSS 10'h1ec
`define PHYMG_IDX_PATTERN_CTRL 10'h1f0

// Reset values.
`define PHYMG_RST_MODE 16'h0040
`define PHYMG_RST_PIN_MUX 16'h417a
`define PHYMG_RST_LINK_LOSS 16'h1ffd
`define PHYMG_RST_PATTERN_CTRL 16'h0000

// Field positions in the mode register.
`define PHYMG_MODE_BRIDGE_BIT 6
`define PHYMG_MODE_MII_BIT 5
`define PHYMG_MODE_OP_MSB 2
`define PHYMG_MODE_OP_LSB 0
// Writable bits of the mode register; the rest read as zero.
`define PHYMG_MODE_WMASK 16'h0067

// Field positions in the pin source register.
`define PHYMG_PIN0_MSB 3
`define PHYMG_PIN0_LSB 0
`define PHYMG_PIN1_MSB 7
`define PHYMG_PIN1_LSB 4

// Link-loss disable bit.
`define PHYMG_LINK_LOSS_DIS_BIT 3

// Pattern control register bits.
`define PHYMG_CTRL_WRAP_BIT 0
`define PHYMG_CTRL_RX_DELIMITER_PULSE_BIT 1
`define PHYMG_CTRL_TX_DELIMITER_PULSE_BIT 2
`define PHYMG_CTRL_WMASK 16'h0007

// Error counter write bits that freeze the packet count.
`define PHYMG_ERR_LOCK_MASK 2'h3

// Saturation value of the packet count.
`define PHYMG_PKT_MAX 32'hffffffff

`endif

// file: design/phymg_pkg.sv
package phymg_pkg;

    typedef enum logic [2:0] {
        PHYMG_OP_RGMII_COPPER = 3'b000,
        PHYMG_OP_RGMII_1000X = 3'b001,
        PHYMG_OP_RGMII_100FX = 3'b010,
        PHYMG_OP_RGMII_SGMII = 3'b011,
        PHYMG_OP_CONV_1000 = 3'b100,
        PHYMG_OP_CONV_100 = 3'b101,
        PHYMG_OP_SGMII_COPPER = 3'b110,
        PHYMG_OP_RESERVED = 3'b111
    } phymg_opmode_t;

    typedef enum logic [3:0] {
        PHYMG_SRC_CLK_OUT = 4'h0,
        PHYMG_SRC_RSVD1 = 4'h1,
        PHYMG_SRC_INT = 4'h2,
        PHYMG_SRC_LINK = 4'h3,
        PHYMG_SRC_RSVD4 = 4'h4,
        PHYMG_SRC_TX_DELIM = 4'h5,
        PHYMG_SRC_RX_DELIM = 4'h6,
        PHYMG_SRC_WAKE = 4'h7,
        PHYMG_SRC_ENERGY = 4'h8,
        PHYMG_SRC_PAT_ERR = 4'h9,
        PHYMG_SRC_IND_TWO = 4'ha,
        PHYMG_SRC_IND_THREE = 4'hb,
        PHYMG_SRC_CRS = 4'hc,
        PHYMG_SRC_COL = 4'hd,
        PHYMG_SRC_ZERO = 4'he,
        PHYMG_SRC_ONE = 4'hf
    } phymg_pin_src_t;

endpackage

// file: design/phymg_pin_mux.sv
`timescale 1ns/1ps
module phymg_pin_mux
    import phymg_pkg::*;
(
    // Selection.
    input wire logic [3:0] sel,
    input wire logic copperMode,
    // Sources.
    input wire logic clkOut,
    input wire logic intr,
    input wire logic linkStatus,
    input wire logic txDelim,
    input wire logic rxDelim,
    input wire logic wakeEvent,
    input wire logic energyDetect,
    input wire logic patternErrors,
    input wire logic indicatorTwo,
    input wire logic indicatorPinThree,
    input wire logic carrierSense,
    input wire logic collision,
    // Result.
    output logic pinValue
);

    // Energy detect has no meaning outside the copper modes, so it is
    // held low there rather than passing a stale level.
    wire logic energyGated = energyDetect & copperMode;

    always_comb begin
        unique case (phymg_pin_src_t'(sel))
            PHYMG_SRC_CLK_OUT: pinValue = clkOut;
            PHYMG_SRC_RSVD1: pinValue = 1'b0;
            PHYMG_SRC_INT: pinValue = intr;
            PHYMG_SRC_LINK: pinValue = linkStatus;
            PHYMG_SRC_RSVD4: pinValue = 1'b0;
            PHYMG_SRC_TX_DELIM: pinValue = txDelim;
            PHYMG_SRC_RX_DELIM: pinValue = rxDelim;
            PHYMG_SRC_WAKE: pinValue = wakeEvent;
            PHYMG_SRC_ENERGY: pinValue = energyGated;
            PHYMG_SRC_PAT_ERR: pinValue = patternErrors;
            PHYMG_SRC_IND_TWO: pinValue = indicatorTwo;
            PHYMG_SRC_IND_THREE: pinValue = indicatorPinThree;
            PHYMG_SRC_CRS: pinValue = carrierSense;
            PHYMG_SRC_COL: pinValue = collision;
            PHYMG_SRC_ZERO: pinValue = 1'b0;
            PHYMG_SRC_ONE: pinValue = 1'b1;
        endcase
    end

endmodule

// file: design/phymg_regs.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "phymg_consts.svh"
module phymg_regs
    import phymg_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pattern checker status.
    input wire logic rxPatternPacket,
    input wire logic [15:0] patternErrorCount,
    // Pin sources.
    input wire logic clkOut,
    input wire logic intr,
    input wire logic linkStatus,
    input wire logic txDelimiterPulse,
    input wire logic rxDelimiterPulse,
    input wire logic wakeEvent,
    input wire logic energyDetect,
    input wire logic patternErrors,
    input wire logic indicatorTwo,
    input wire logic indicatorPinThree,
    input wire logic carrierSense,
    input wire logic collision,
    // Configuration outputs.
    output logic [2:0] operationModeField,
    output logic bridgeDirectionSelect,
    output logic miiSelect,
    output logic linkLossDisable,
    output logic countWrap,
    output logic rxSfdEnable,
    output logic txSfdEnable,
    // General purpose pins.
    output logic pin0Out,
    output logic pin1Out
);

    function automatic logic regHit(input logic [9:0] idx,
                                    input logic [9:0] target);
        regHit = (idx == target);
    endfunction

    // Register state.
    logic [15:0] modeReg;
    logic [15:0] pinMuxReg;
    logic [15:0] linkLossReg;
    logic [15:0] ctrlReg;
    logic [31:0] rxPatternPackets;
    logic [31:0] frozenPackets;

    // Bus pipeline state.
    logic wrPend;
    logic [9:0] wrIdx;
    logic rdPend;
    logic [9:0] rdIdx;

    // Address phase decode.
    wire logic addrValid = hsel & htrans[1] & hready;
    wire logic takeWrite = addrValid & hwrite;
    wire logic takeRead = addrValid & ~hwrite;
    wire logic [9:0] addrIdx = haddr[11:2];

    // Data phase write strobes.
    wire logic wrMode = wrPend & regHit(wrIdx, `PHYMG_IDX_MODE);
    wire logic wrPinMux = wrPend & regHit(wrIdx, `PHYMG_IDX_PIN_MUX);
    wire logic wrLinkLoss = wrPend & regHit(wrIdx, `PHYMG_IDX_LINK_LOSS);
    wire logic wrCtrl = wrPend & regHit(wrIdx, `PHYMG_IDX_PATTERN_CTRL);
    wire logic wrErrCnt = wrPend & regHit(wrIdx, `PHYMG_IDX_ERR_CNT);
    wire logic freezeCount =
        wrErrCnt & (|(hwdata[1:0] & `PHYMG_ERR_LOCK_MASK));

    // Next register values.
    wire logic [15:0] next_modeReg =
        wrMode ? (hwdata[15:0] & `PHYMG_MODE_WMASK) : modeReg;
    wire logic [15:0] next_pinMuxReg =
        wrPinMux ? hwdata[15:0] : pinMuxReg;
    wire logic [15:0] next_linkLossReg =
        wrLinkLoss ? hwdata[15:0] : linkLossReg;
    wire logic [15:0] next_ctrlReg =
        wrCtrl ? (hwdata[15:0] & `PHYMG_CTRL_WMASK) : ctrlReg;

    // Packet counter: wrap only when the count mode bit is set.
    wire logic countWrapNow = ctrlReg[`PHYMG_CTRL_WRAP_BIT];
    wire logic atMax = (rxPatternPackets == `PHYMG_PKT_MAX);
    wire logic countStep =
        rxPatternPacket & (countWrapNow | ~atMax);
    wire logic [31:0] next_rxPatternPackets =
        countStep ? rxPatternPackets + 32'h00000001 : rxPatternPackets;
    // The snapshot keeps both halves consistent across two reads.
    wire logic [31:0] next_frozenPackets =
        freezeCount ? rxPatternPackets : frozenPackets;

    // Read data selection.
    logic [15:0] readValue;
    always_comb begin
        readValue = 16'h0000;
        if (regHit(rdIdx, `PHYMG_IDX_PKT_LOW)) begin
            readValue = frozenPackets[15:0];
        end else if (regHit(rdIdx, `PHYMG_IDX_PKT_HIGH)) begin
            readValue = frozenPackets[31:16];
        end else if (regHit(rdIdx, `PHYMG_IDX_ERR_CNT)) begin
            readValue = patternErrorCount;
        end else if (regHit(rdIdx, `PHYMG_IDX_MODE)) begin
            readValue = modeReg;
        end else if (regHit(rdIdx, `PHYMG_IDX_PIN_MUX)) begin
            readValue = pinMuxReg;
        end else if (regHit(rdIdx, `PHYMG_IDX_LINK_LOSS)) begin
            readValue = linkLossReg;
        end else if (regHit(rdIdx, `PHYMG_IDX_PATTERN_CTRL)) begin
            readValue = ctrlReg;
        end
    end
    wire logic [31:0] next_hrdata =
        rdPend ? {16'h0000, readValue} : hrdata;

    // Reads take one wait state so a read right after a write sees the
    // written value; writes complete with no wait.
    wire logic next_hreadyout = ~takeRead;

    // Pin routing.
    wire logic [2:0] opNow = modeReg[`PHYMG_MODE_OP_MSB:`PHYMG_MODE_OP_LSB];
    wire logic copperMode =
        (phymg_opmode_t'(opNow) == PHYMG_OP_RGMII_COPPER) |
        (phymg_opmode_t'(opNow) == PHYMG_OP_CONV_1000) |
        (phymg_opmode_t'(opNow) == PHYMG_OP_CONV_100) |
        (phymg_opmode_t'(opNow) == PHYMG_OP_SGMII_COPPER);
    wire logic sfdAny = ctrlReg[`PHYMG_CTRL_RX_DELIMITER_PULSE_BIT] |
        ctrlReg[`PHYMG_CTRL_TX_DELIMITER_PULSE_BIT];
    wire logic [3:0] pinSel [2];
    wire logic muxValue [2];
    assign pinSel[0] = pinMuxReg[`PHYMG_PIN0_MSB:`PHYMG_PIN0_LSB];
    assign pinSel[1] = pinMuxReg[`PHYMG_PIN1_MSB:`PHYMG_PIN1_LSB];

    generate
        for (genvar g = 0; g < 2; g++) begin : gen_pin
            phymg_pin_mux u_mux (
                .sel(pinSel[g]),
                .copperMode(copperMode),
                .clkOut(clkOut),
                .intr(intr),
                .linkStatus(linkStatus),
                .txDelim(txDelimiterPulse),
                .rxDelim(rxDelimiterPulse),
                .wakeEvent(wakeEvent),
                .energyDetect(energyDetect),
                .patternErrors(patternErrors),
                .indicatorTwo(indicatorTwo),
                .indicatorPinThree(indicatorPinThree),
                .carrierSense(carrierSense),
                .collision(collision),
                .pinValue(muxValue[g])
            );
        end
    endgenerate

    // The pins lag their sources by one clock because they are registered.
    wire logic next_pin0Out = sfdAny ? rxDelimiterPulse : muxValue[0];
    wire logic next_pin1Out = sfdAny ? txDelimiterPulse : muxValue[1];

    // Bus pipeline.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wrPend <= 1'b0;
            wrIdx <= 10'h000;
            rdPend <= 1'b0;
            rdIdx <= 10'h000;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end else begin
            wrPend <= takeWrite;
            wrIdx <= takeWrite ? addrIdx : wrIdx;
            rdPend <= takeRead;
            rdIdx <= takeRead ? addrIdx : rdIdx;
            hreadyout <= next_hreadyout;
            hrdata <= next_hrdata;
            hresp <= 1'b0;
        end
    end

    // Configuration registers.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            modeReg <= `PHYMG_RST_MODE;
            pinMuxReg <= `PHYMG_RST_PIN_MUX;
            linkLossReg <= `PHYMG_RST_LINK_LOSS;
            ctrlReg <= `PHYMG_RST_PATTERN_CTRL;
        end else begin
            modeReg <= next_modeReg;
            pinMuxReg <= next_pinMuxReg;
            linkLossReg <= next_linkLossReg;
            ctrlReg <= next_ctrlReg;
        end
    end

    // Packet count and its frozen copy.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rxPatternPackets <= 32'h00000000;
            frozenPackets <= 32'h00000000;
        end else begin
            rxPatternPackets <= next_rxPatternPackets;
            frozenPackets <= next_frozenPackets;
        end
    end

    // Registered outputs.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            operationModeField <= 3'h0;
            bridgeDirectionSelect <= 1'b1;
            miiSelect <= 1'b0;
            linkLossDisable <= 1'b1;
            countWrap <= 1'b0;
            rxSfdEnable <= 1'b0;
            txSfdEnable <= 1'b0;
            pin0Out <= 1'b0;
            pin1Out <= 1'b0;
        end else begin
            operationModeField <= opNow;
            bridgeDirectionSelect <= modeReg[`PHYMG_MODE_BRIDGE_BIT];
            miiSelect <= modeReg[`PHYMG_MODE_MII_BIT];
            linkLossDisable <=
                linkLossReg[`PHYMG_LINK_LOSS_DIS_BIT];
            countWrap <= countWrapNow;
            rxSfdEnable <= ctrlReg[`PHYMG_CTRL_RX_DELIMITER_PULSE_BIT];
            txSfdEnable <= ctrlReg[`PHYMG_CTRL_TX_DELIMITER_PULSE_BIT];
            pin0Out <= next_pin0Out;
            pin1Out <= next_pin1Out;
        end
    end

endmodule

// file: design/phymg_regs_end.sv
`timescale 1ns/1ps

// file: testbench/phymg_regs_assertions.sv
`timescale 1ns/1ps
`include "phymg_consts.svh"
module phymg_regs_assertions (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register bus.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins and configuration.
    input wire logic rxDelimiterPulse,
    input wire logic txDelimiterPulse,
    input wire logic rxSfdEnable,
    input wire logic txSfdEnable,
    input wire logic pin0Out,
    input wire logic pin1Out,
    input wire logic [2:0] operationModeField,
    input wire logic bridgeDirectionSelect,
    input wire logic linkLossDisable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic taken = hsel & htrans[1] & hready;
    wire logic rdTaken = taken & !hwrite;
    wire logic modeWr = taken & hwrite & (haddr[11:2] == `PHYMG_IDX_MODE);
    wire logic lossWr = taken & hwrite &
        (haddr[11:2] == `PHYMG_IDX_LINK_LOSS);
    wire logic sfdOn = rxSfdEnable | txSfdEnable;

    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_upper_zero; hrdata[31:16] == 16'h0; endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read half not zero");
    property p_read_wait; rdTaken |=> !hreadyout ##1 hreadyout; endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state wrong");
    property p_wait_cause; !hreadyout |-> $past(rdTaken); endproperty
    a_wait_cause: assert property (p_wait_cause)
        else $error("wait state without a read");
    // Address phase, data phase, register and output flop: a config
    // output shows its change three samples after the write was taken.
    property p_mode; $changed(operationModeField) |-> $past(modeWr, 3);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode field moved without a write");
    property p_bridge;
        $changed(bridgeDirectionSelect) |-> $past(modeWr, 3);
    endproperty
    a_bridge: assert property (p_bridge)
        else $error("bridge select moved without a write");
    property p_loss; $changed(linkLossDisable) |-> $past(lossWr, 3);
    endproperty
    a_loss: assert property (p_loss)
        else $error("link loss moved without a write");
    // The enable outputs and the pins both lag the control register by
    // one clock, so they line up in the same sample.
    property p_pin0_sfd; sfdOn |-> pin0Out == $past(rxDelimiterPulse);
    endproperty
    a_pin0_sfd: assert property (p_pin0_sfd)
        else $error("pin 0 not on rx delimiter");
    property p_pin1_sfd; sfdOn |-> pin1Out == $past(txDelimiterPulse);
    endproperty
    a_pin1_sfd: assert property (p_pin1_sfd)
        else $error("pin 1 not on tx delimiter");
endmodule

// file: testbench/phymg_regs_tb_top.sv
`timescale 1ns/1ps
`include "phymg_consts.svh"
module phymg_regs_tb_top;
    logic clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, pkt = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [15:0] errCnt = 0, w;
    logic [11:0] src = 0;
    logic [2:0] opMode, curMode;
    logic hreadyout, hresp, bridge, lossDis, pin0, pin1;
    logic mii, wrapOut, rxSfd, txSfd;
    int nErrors = 0, samplesChecked = 0, n;

    always #25 clk_sys = ~clk_sys;

    phymg_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rxPatternPacket(pkt),
        .patternErrorCount(errCnt), .clkOut(src[0]), .intr(src[1]),
        .linkStatus(src[2]), .txDelimiterPulse(src[3]),
        .rxDelimiterPulse(src[4]), .wakeEvent(src[5]),
        .energyDetect(src[6]), .patternErrors(src[7]),
        .indicatorTwo(src[8]), .indicatorPinThree(src[9]),
        .carrierSense(src[10]), .collision(src[11]),
        .operationModeField(opMode), .bridgeDirectionSelect(bridge),
        .miiSelect(mii), .linkLossDisable(lossDis), .countWrap(wrapOut),
        .rxSfdEnable(rxSfd), .txSfdEnable(txSfd), .pin0Out(pin0),
        .pin1Out(pin1));

    function logic expPin(input logic [3:0] c, input logic [2:0] m);
        if (c == 4'hf) return 1'b1;
        if (c == 4'h8 && !(m == 3'h0 || (m > 3'h3 && m < 3'h7)))
            return 1'b0;
        if (c == 4'h0) return src[0];
        if (c == 4'h2 || c == 4'h3) return src[c - 4'h1];
        if (c >= 4'h5 && c <= 4'hd) return src[c - 4'h2];
        return 1'b0;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The master waits for hready without assuming a latency.
    task bus(input logic wr, input logic [9:0] idx, input logic [15:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, idx, 2'h0};
        hwrite <= wr;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask

    task rdchk(input logic [9:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0);
        chk(rd, {16'h0, exp});
    endtask

    task pins(input logic [3:0] c, input logic sfd);
        repeat (4) begin
            @(posedge clk_sys);
            src <= 12'($urandom);
            repeat (2) @(posedge clk_sys);
            chk(pin0, sfd ? src[4] : expPin(c, curMode));
            chk(pin1, sfd ? src[3] : expPin(4'hf - c, curMode));
        end
    endtask

    task pulses(input int k);
        repeat (k) begin
            @(posedge clk_sys);
            pkt <= 1'b1;
        end
        @(posedge clk_sys);
        pkt <= 1'b0;
    endtask

    task wrapUp;
        $display("checks=%0d mismatches=%0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        n = $urandom(50);
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdchk(`PHYMG_IDX_MODE, `PHYMG_RST_MODE);
        rdchk(`PHYMG_IDX_PIN_MUX, `PHYMG_RST_PIN_MUX);
        rdchk(`PHYMG_IDX_LINK_LOSS, `PHYMG_RST_LINK_LOSS);
        rdchk(`PHYMG_IDX_PKT_HIGH, 16'h0);
        rdchk(10'h3ff, 16'h0);
        chk(bridge, 32'h1);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            w = 16'($urandom);
            w[2:0] = 3'(c);
            bus(1'b1, `PHYMG_IDX_MODE, w);
            rdchk(`PHYMG_IDX_MODE, w & `PHYMG_MODE_WMASK);
            chk(opMode, c);
            chk(bridge, w[6]);
            chk(mii, w[5]);
        end
        $display("test mode done");
        n = $urandom_range(60, 20);
        pulses(n);
        bus(1'b1, `PHYMG_IDX_PKT_LOW, 16'hffff);
        bus(1'b1, `PHYMG_IDX_ERR_CNT, 16'hfffc);
        rdchk(`PHYMG_IDX_PKT_LOW, 16'h0);
        bus(1'b1, `PHYMG_IDX_ERR_CNT, 16'h0001);
        rdchk(`PHYMG_IDX_PKT_LOW, 16'(n));
        pulses(65536);
        rdchk(`PHYMG_IDX_PKT_LOW, 16'(n));
        bus(1'b1, `PHYMG_IDX_ERR_CNT, 16'h0002);
        rdchk(`PHYMG_IDX_PKT_LOW, 16'(n));
        rdchk(`PHYMG_IDX_PKT_HIGH, 16'h1);
        w = 16'($urandom);
        errCnt <= w;
        rdchk(`PHYMG_IDX_ERR_CNT, w);
        $display("test count done");
        for (int c = 0; c < 16; c++) begin
            curMode = 3'(c % 7);
            bus(1'b1, `PHYMG_IDX_MODE, 16'(curMode));
            w = {8'h0, 4'(15 - c), 4'(c)};
            bus(1'b1, `PHYMG_IDX_PIN_MUX, w);
            rdchk(`PHYMG_IDX_PIN_MUX, w);
            pins(4'(c), 1'b0);
        end
        for (int b = 1; b < 3; b++) begin
            bus(1'b1, `PHYMG_IDX_PATTERN_CTRL, 16'h1 << b);
            rdchk(`PHYMG_IDX_PATTERN_CTRL, 16'h1 << b);
            pins(4'hf, 1'b1);
            chk(rxSfd, 32'(b == 1));
            chk(txSfd, 32'(b == 2));
        end
        bus(1'b1, `PHYMG_IDX_PATTERN_CTRL, 16'hfff9);
        rdchk(`PHYMG_IDX_PATTERN_CTRL, 16'h0001);
        chk(wrapOut, 32'h1);
        bus(1'b1, `PHYMG_IDX_PATTERN_CTRL, 16'h0);
        rdchk(`PHYMG_IDX_PATTERN_CTRL, 16'h0000);
        chk(wrapOut, 32'h0);
        chk(rxSfd | txSfd, 32'h0);
        $display("test pins done");
        bus(1'b1, `PHYMG_IDX_LINK_LOSS, 16'h0);
        rdchk(`PHYMG_IDX_LINK_LOSS, 16'h0);
        chk(lossDis, 32'h0);
        bus(1'b1, `PHYMG_IDX_LINK_LOSS, 16'hffff);
        rdchk(`PHYMG_IDX_LINK_LOSS, 16'hffff);
        chk(lossDis, 32'h1);
        $display("test link loss done");
        wrapUp;
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        nErrors++;
        wrapUp;
    end
endmodule

bind phymg_regs phymg_regs_assertions u_chk (.clk_sys, .rst_n, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
    .rxDelimiterPulse, .txDelimiterPulse, .rxSfdEnable, .txSfdEnable,
    .pin0Out, .pin1Out, .operationModeField, .bridgeDirectionSelect,
    .linkLossDisable);
